// *** smbus_target_interface.sv ***
// Two-wire SMBus/I2C target port with pointer, timeout and alert query
// Summary of operation
// - Ignore bus for 15ms after power-up
// - Start: data falls while clock high
// - First byte: 7-bit address plus direction
// - Strap code selects one of six addresses
// - Fixed variants answer 1001100 or 1001101
// - Bytes are eight bits, MSB first
// - Acknowledge address and first two received bytes on ninth clock
// - Stop: data rises while clock high, reset
// - Clock low beyond 30ms resets protocol
// - Timeout disabled after reset, enabled by software
// - Foreign address: silent, unchanged; bad protocol: no register write
// - Clock stretching tolerated, clock never driven
// - Write Byte stores data in indexed register
// - Read Byte: index, repeated start, one byte
// - Send Byte only loads register pointer
// - Receive Byte returns register at pointer
// - Alert query answered with own address
// - Full address sent, then set alert mask
// - Alert query leaves status flags alone
// - Mask set keeps alert output released
`timescale 1ns/1ps
`include "smb_target_consts.svh"

module smbus_target_interface #(
    parameter int       BLACKOUT_CYCLES = `BLACKOUT_CYC,
    parameter int       TIMEOUT_CYCLES  = `TIMEOUT_CYC,
    parameter bit [1:0] VARIANT         = `VARIANT_STRAP
) (
    input  wire logic                    clk,
    input  wire logic                    reset_n,
    input  wire logic                    serial_clock_line,
    input  wire logic                    sda_in,
    output      logic                    sda_out,
    output      logic                    sda_oe,
    input  wire logic [2:0]              strap_code,
    input  wire logic                    timeout_en,
    input  wire logic                    alert_pending,
    input  wire logic                    alert_mask,
    input  wire logic [7:0]              reg_rdata,
    output      smb_target_pkg::reg_wr_t reg_wr,
    output      logic [7:0]              reg_ptr,
    output      logic                    mask_set,
    output      logic                    alert_oe,
    output      logic                    ready
);
    import smb_target_pkg::*;

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic       scl_s1_r, scl_s2_r, scl_d_r;
    logic       sda_s1_r, sda_s2_r, sda_d_r;
    logic [2:0] strap_s1_r, strap_s2_r;
    logic       scl_rise, scl_fall, start_det, stop_det;
    logic [31:0] boot_cnt_r;
    logic       ready_r;
    logic [31:0] to_cnt_r;
    logic       timeout_hit;
    logic [6:0] own_r;
    smb_state_t state_r;
    logic [3:0] bit_cnt_r;
    logic [1:0] byte_cnt_r;
    logic [7:0] sh_r;
    logic [7:0] tx_r;
    logic       reading_r;
    logic       query_r;
    logic       sda_oe_r;
    logic [7:0] ptr_r;
    logic [7:0] wdata_r;
    reg_wr_t    reg_wr_r;
    logic       mask_set_r;
    logic       alert_oe_r;
    logic       abort;

    // Strap resistor code to 7-bit address; unknown codes fall back to 10k
    function automatic logic [6:0] strap_addr(input logic [2:0] code);
        case (code)
            3'h0:    strap_addr = `STRAP_ADDR_4K7;
            3'h1:    strap_addr = `STRAP_ADDR_6K8;
            3'h2:    strap_addr = `STRAP_ADDR_10K;
            3'h3:    strap_addr = `STRAP_ADDR_15K;
            3'h4:    strap_addr = `STRAP_ADDR_22K;
            3'h5:    strap_addr = `STRAP_ADDR_33K;
            default: strap_addr = `STRAP_ADDR_10K;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // Pin synchronisers and bus event detection
    // ----------------------------------------------------------------
    // Two stages before any logic; the third stage gives edges
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            scl_s1_r <= 1'b1;
            scl_s2_r <= 1'b1;
            scl_d_r  <= 1'b1;
            sda_s1_r <= 1'b1;
            sda_s2_r <= 1'b1;
            sda_d_r  <= 1'b1;
        end
        else
        begin
            scl_s1_r <= serial_clock_line;
            scl_s2_r <= scl_s1_r;
            scl_d_r  <= scl_s2_r;
            sda_s1_r <= sda_in;
            sda_s2_r <= sda_s1_r;
            sda_d_r  <= sda_s2_r;
        end
    end

    // Strap code is a slow analog decision, synchronised like a pin
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            strap_s1_r <= 3'h0;
            strap_s2_r <= 3'h0;
        end
        else
        begin
            strap_s1_r <= strap_code;
            strap_s2_r <= strap_s1_r;
        end
    end

    // Edge and condition decode; clock stretching just lengthens phases
    assign scl_rise  = scl_s2_r & ~scl_d_r;
    assign scl_fall  = ~scl_s2_r & scl_d_r;
    assign start_det = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
    assign stop_det  = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;

    // ----------------------------------------------------------------
    // Power-up blackout and address capture
    // ----------------------------------------------------------------
    // Bus is ignored until the count expires
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            boot_cnt_r <= 32'h0;
            ready_r    <= 1'b0;
        end
        else if (!ready_r)
        begin
            boot_cnt_r <= boot_cnt_r + 32'h1;
            ready_r    <= (boot_cnt_r == 32'(BLACKOUT_CYCLES - 1));
        end
    end

    // Address is taken once, as the blackout ends, so a pin pulled
    // low early only matters if it is still low at that moment
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            own_r <= `FIXED_ADDR_A;
        else if (!ready_r)
        begin
            if (VARIANT == `VARIANT_FIXED_A)
                own_r <= `FIXED_ADDR_A;
            else if (VARIANT == `VARIANT_FIXED_B)
                own_r <= `FIXED_ADDR_B;
            else
                own_r <= strap_addr(strap_s2_r);
        end
    end

    // ----------------------------------------------------------------
    // Clock-low timeout
    // ----------------------------------------------------------------
    // Counter is held at zero while disabled, which is the reset state
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            to_cnt_r <= 32'h0;
        else if (!timeout_en || scl_s2_r || timeout_hit)
            to_cnt_r <= 32'h0;
        else
            to_cnt_r <= to_cnt_r + 32'h1;
    end

    assign timeout_hit = (to_cnt_r == 32'(TIMEOUT_CYCLES));
    assign abort       = !ready_r || timeout_hit;

    // ----------------------------------------------------------------
    // Protocol engine
    // ----------------------------------------------------------------
    // Data changes only while the clock is low; sda_oe high pulls low
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_r    <= ST_IDLE;
            bit_cnt_r  <= 4'h0;
            byte_cnt_r <= 2'h0;
            sh_r       <= 8'h0;
            tx_r       <= 8'h0;
            reading_r  <= 1'b0;
            query_r    <= 1'b0;
            sda_oe_r   <= 1'b0;
            ptr_r      <= 8'h0;
            wdata_r    <= 8'h0;
            reg_wr_r   <= '0;
            mask_set_r <= 1'b0;
        end
        else
        begin
            reg_wr_r.en <= 1'b0;
            mask_set_r  <= 1'b0;
            if (abort)
            begin
                state_r  <= ST_IDLE;
                sda_oe_r <= 1'b0;
            end
            else if (start_det)
            begin
                state_r    <= ST_RX;
                bit_cnt_r  <= 4'h0;
                byte_cnt_r <= 2'h0;
                query_r    <= 1'b0;
                sda_oe_r   <= 1'b0;
            end
            else if (stop_det)
            begin
                // Commit only a complete Write Byte
                if (state_r == ST_RX && bit_cnt_r == 4'h1 &&
                    byte_cnt_r == 2'h3 && !reading_r)
                begin
                    reg_wr_r.en   <= 1'b1;
                    reg_wr_r.idx  <= ptr_r;
                    reg_wr_r.data <= wdata_r;
                end
                state_r  <= ST_IDLE;
                sda_oe_r <= 1'b0;
            end
            else
            begin
                unique case (state_r)
                    ST_IDLE: ;
                    ST_RX:
                    begin
                        if (scl_rise)
                        begin
                            sh_r      <= {sh_r[6:0], sda_s2_r};
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                        end
                        else if (scl_fall && bit_cnt_r == `BITS_PER_BYTE)
                        begin
                            bit_cnt_r <= 4'h0;
                            if (byte_cnt_r == 2'h0 &&
                                (sh_r[7:1] == own_r ||
                                 (sh_r[7:1] == `ALERT_QUERY_ADDR &&
                                  sh_r[`RW_BIT] && alert_oe_r)))
                            begin
                                reading_r  <= sh_r[`RW_BIT];
                                query_r    <= sh_r[7:1] != own_r;
                                byte_cnt_r <= 2'h1;
                                state_r    <= ST_ACK;
                                sda_oe_r   <= 1'b1;
                            end
                            else if (byte_cnt_r == 2'h1)
                            begin
                                ptr_r      <= sh_r;
                                byte_cnt_r <= 2'h2;
                                state_r    <= ST_ACK;
                                sda_oe_r   <= 1'b1;
                            end
                            else if (byte_cnt_r == 2'h2)
                            begin
                                wdata_r    <= sh_r;
                                byte_cnt_r <= 2'h3;
                                state_r    <= ST_ACK;
                                sda_oe_r   <= 1'b1;
                            end
                            else
                                state_r <= ST_IDLE;
                        end
                    end
                    ST_ACK:
                    begin
                        // Acknowledge held for one full clock high
                        if (scl_fall)
                        begin
                            bit_cnt_r <= 4'h0;
                            if (reading_r)
                            begin
                                tx_r     <= query_r ? {own_r, 1'b0}
                                                    : reg_rdata;
                                sda_oe_r <= query_r ? ~own_r[6]
                                                    : ~reg_rdata[7];
                                state_r  <= ST_TX;
                            end
                            else
                            begin
                                sda_oe_r <= 1'b0;
                                state_r  <= ST_RX;
                            end
                        end
                    end
                    ST_TX:
                    begin
                        if (scl_rise)
                        begin
                            // A released one read back low means lost arbitration
                            if (sda_s2_r != tx_r[7])
                            begin
                                sda_oe_r <= 1'b0;
                                query_r  <= 1'b0;
                                state_r  <= ST_IDLE;
                            end
                            else
                                bit_cnt_r <= bit_cnt_r + 4'h1;
                        end
                        else if (scl_fall)
                        begin
                            if (bit_cnt_r == `BITS_PER_BYTE)
                            begin
                                sda_oe_r   <= 1'b0;
                                mask_set_r <= query_r;
                                state_r    <= ST_RACK;
                            end
                            else
                            begin
                                tx_r     <= {tx_r[6:0], 1'b0};
                                sda_oe_r <= ~tx_r[6];
                            end
                        end
                    end
                    ST_RACK:
                    begin
                        // One byte per read; host ends with nack and stop
                        if (scl_rise)
                            state_r <= ST_IDLE;
                    end
                    default: state_r <= ST_IDLE;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Alert output
    // ----------------------------------------------------------------
    // Status flags live outside and are never touched here
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            alert_oe_r <= 1'b0;
        else
            alert_oe_r <= alert_pending & ~alert_mask;
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign sda_out  = 1'b0;
    assign sda_oe   = sda_oe_r;
    assign reg_wr   = reg_wr_r;
    assign reg_ptr  = ptr_r;
    assign mask_set = mask_set_r;
    assign alert_oe = alert_oe_r;
    assign ready    = ready_r;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    AST_SILENT_BLACKOUT: assert property (!ready_r |=> !sda_oe_r)
        else $error("data driven during blackout");
    AST_START_RX: assert property (start_det && !abort |=> state_r == ST_RX)
        else $error("start not taken");
    AST_STOP_IDLE: assert property (stop_det && !abort |=> state_r == ST_IDLE && !sda_oe_r)
        else $error("stop did not reset port");
    AST_INDEX_ACK: assert property (state_r == ST_RX && scl_fall && !abort &&
        !start_det && !stop_det && bit_cnt_r == 4'h8 && byte_cnt_r == 2'h1
        |=> sda_oe_r && state_r == ST_ACK && ptr_r == $past(sh_r))
        else $error("index byte not acked or pointer not loaded");
    AST_WRITE_AT_STOP: assert property (reg_wr_r.en |-> $past(stop_det) && !$past(reading_r))
        else $error("write outside write stop");
    AST_TIMEOUT_RESET: assert property (timeout_hit |=> state_r == ST_IDLE && !sda_oe_r)
        else $error("timeout did not reset port");
    AST_TIMEOUT_OFF: assert property (!timeout_en |=> to_cnt_r == 32'h0)
        else $error("timeout counting while disabled");
    AST_MASK_QUIET: assert property (alert_mask |=> !alert_oe_r)
        else $error("alert driven while masked");
    AST_MASK_SET_QUERY: assert property (mask_set_r |-> $past(query_r) && state_r == ST_RACK)
        else $error("mask set without full query reply");

endmodule // smbus_target_interface

// *** smb_target_consts.svh ***
// Constants for the two-wire target port: addresses, timing counts
`ifndef SMB_TARGET_CONSTS_SVH
`define SMB_TARGET_CONSTS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_FREQ_KHZ     20000
`define BLACKOUT_MS      15
`define BLACKOUT_CYC     (`BLACKOUT_MS * `CLK_FREQ_KHZ)
`define TIMEOUT_MS       30
`define TIMEOUT_CYC      (`TIMEOUT_MS * `CLK_FREQ_KHZ)

// ----------------------------------------------------------------
// Addresses (7-bit)
// ----------------------------------------------------------------
`define ALERT_QUERY_ADDR 7'h0c
`define FIXED_ADDR_A     7'h4c
`define FIXED_ADDR_B     7'h4d
`define STRAP_ADDR_4K7   7'h7c
`define STRAP_ADDR_6K8   7'h5c
`define STRAP_ADDR_10K   7'h4c
`define STRAP_ADDR_15K   7'h6c
`define STRAP_ADDR_22K   7'h1c
`define STRAP_ADDR_33K   7'h3c

// ----------------------------------------------------------------
// Byte layout and variant codes
// ----------------------------------------------------------------
`define BITS_PER_BYTE    4'h8
`define RW_BIT           0
`define VARIANT_STRAP    2'h0
`define VARIANT_FIXED_A  2'h1
`define VARIANT_FIXED_B  2'h2

`endif

// *** smb_target_pkg.sv ***
// Types shared by the two-wire target port
package smb_target_pkg;

    // Protocol states, one-hot
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_RX   = 5'h02,
        ST_ACK  = 5'h04,
        ST_TX   = 5'h08,
        ST_RACK = 5'h10
    } smb_state_t;

    // Register write request toward the register file
    typedef struct packed {
        logic       en;
        logic [7:0] idx;
        logic [7:0] data;
    } reg_wr_t;

endpackage

// *** smb_host_model.sv ***
// Host controller model that masters the two-wire bus by bit-banging
`timescale 1ns/1ps

module smb_host_model (
    input  wire logic clk,
    input  wire logic sda_line,
    output      logic scl,
    output      logic sda_pull
);

    // Bus idles with the clock high and the data line released to the pull-up
    initial
    begin
        scl      = 1'b1;
        sda_pull = 1'b0;
    end

    // ------------------------------------------------------------
    // Bit timing: 5 clk low, 3 clk high, one 400 ns bus period
    // ------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // One clock pulse; data is set early in the low phase, sampled mid-high
    task automatic clock_bit(input logic drive_low, output logic seen);
        sda_pull = drive_low;
        tick(3);
        scl = 1'b1;
        tick(2);
        seen = sda_line;
        tick(1);
        scl = 1'b0;
        tick(2);
    endtask

    // Start or repeated start; waits first so a target ack is surely released
    task automatic bus_start();
        sda_pull = 1'b0;
        tick(4);
        scl = 1'b1;
        tick(4);
        sda_pull = 1'b1;
        tick(4);
        scl = 1'b0;
        tick(2);
    endtask

    // Stop, then some bus free time before anything else
    task automatic bus_stop();
        sda_pull = 1'b1;
        tick(4);
        scl = 1'b1;
        tick(4);
        sda_pull = 1'b0;
        tick(8);
    endtask

    // Eight bits out, then the target's ack clock
    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic seen;
        for (int i = 7; i >= 0; i--)
            clock_bit(~b[i], seen);
        clock_bit(1'b0, seen);
        ack = ~seen;
    endtask

    // Eight bits in; a final byte is answered with the line left high
    task automatic get_byte(input logic last, output logic [7:0] b);
        logic seen;
        for (int i = 7; i >= 0; i--)
        begin
            clock_bit(1'b0, seen);
            b[i] = seen;
        end
        clock_bit(~last, seen);
    endtask

endmodule // smb_host_model

// *** tb_top.sv ***
// Self-checking testbench for the two-wire target port
`timescale 1ns/1ps
`include "smb_target_consts.svh"

module tb_top;
    import smb_target_pkg::*;

    localparam int BLACKOUT = 2000;
    localparam int TMO      = 200;

    logic                   clk;
    logic                   reset_n;
    logic                   scl;
    logic                   host_pull;
    logic                   sda_line;
    logic                   sda_out;
    logic                   sda_oe;
    logic                   timeout_en;
    logic                   alert_pending;
    logic                   alert_mask;
    logic                   mask_set;
    logic                   alert_oe;
    logic                   ready;
    logic [2:0]             strap_code;
    logic [7:0]             reg_rdata;
    logic [7:0]             reg_ptr;
    reg_wr_t                reg_wr;
    logic [7:0]             rf [256];
    int                     exp_mem [256];
    int                     exp_ptr;
    logic [15:0]            wr_q [$];
    logic [6:0]             own;
    int                     n_errors = 0;
    int                     cmp_count = 0;

    // Wired-AND data line with pull-up; either party pulls it low
    assign sda_line  = (sda_oe ? sda_out : 1'b1) & ~host_pull;
    assign reg_rdata = rf[reg_ptr];

    initial clk = 1'b0;
    always #25 clk = ~clk;

    smbus_target_interface #(
        .BLACKOUT_CYCLES (BLACKOUT),
        .TIMEOUT_CYCLES  (TMO)
    ) dut (
        .clk               (clk),
        .reset_n           (reset_n),
        .serial_clock_line (scl),
        .sda_in            (sda_line),
        .sda_out           (sda_out),
        .sda_oe            (sda_oe),
        .strap_code        (strap_code),
        .timeout_en        (timeout_en),
        .alert_pending     (alert_pending),
        .alert_mask        (alert_mask),
        .reg_rdata         (reg_rdata),
        .reg_wr            (reg_wr),
        .reg_ptr           (reg_ptr),
        .mask_set          (mask_set),
        .alert_oe          (alert_oe),
        .ready             (ready)
    );

    smb_host_model host (
        .clk      (clk),
        .sda_line (sda_line),
        .scl      (scl),
        .sda_pull (host_pull)
    );

    // Register file and alert mask kept outside the port, as in the device
    always @(posedge clk)
    begin
        if (reg_wr.en === 1'b1)
        begin
            rf[reg_wr.idx] <= reg_wr.data;
            wr_q.push_back({reg_wr.idx, reg_wr.data});
        end
        if (mask_set === 1'b1)
            alert_mask <= 1'b1;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    function automatic logic [6:0] strap_addr(input int s);
        case (s)
            0:       return `STRAP_ADDR_4K7;
            1:       return `STRAP_ADDR_6K8;
            2:       return `STRAP_ADDR_10K;
            3:       return `STRAP_ADDR_15K;
            4:       return `STRAP_ADDR_22K;
            5:       return `STRAP_ADDR_33K;
            default: return `STRAP_ADDR_10K;
        endcase
    endfunction

    // Write-direction transaction: address, n bytes, optional stretch after address
    task automatic wr_txn(input logic [6:0] a, input int n, input logic [23:0] b,
                          input int hold, input bit stop, output logic [3:0] acks);
        logic ack;
        acks = 4'h0;
        host.bus_start();
        host.put_byte({a, 1'b0}, ack);
        acks[0] = ack;
        host.tick(hold);
        for (int i = 0; i < n; i++)
        begin
            host.put_byte(b[23 - 8 * i -: 8], ack);
            acks[i + 1] = ack;
        end
        if (stop)
            host.bus_stop();
    endtask

    // Single-byte read with a closing not-acknowledge
    task automatic rd_txn(input logic [6:0] a, output logic ack, output logic [7:0] d);
        host.bus_start();
        host.put_byte({a, 1'b1}, ack);
        host.get_byte(1'b1, d);
        host.bus_stop();
    endtask

    // Observed commits against the model's expectation, then forget them
    task automatic chk_wr(input bit one, input logic [15:0] ent);
        host.tick(8);
        chk(16'(wr_q.size()), 16'(one));
        if (one && wr_q.size() > 0)
            chk(wr_q[0], ent);
        wr_q.delete();
    endtask

    // Watchdog sized well above the roughly 20k cycles the tests need
    initial
    begin
        repeat (80000) @(posedge clk);
        n_errors++;
        report_and_stop();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        logic [7:0] idx;
        logic [7:0] dat;
        logic [7:0] got;
        logic [3:0] acks;
        logic       ack;
        reset_n       = 1'b0;
        strap_code    = 3'h0;
        timeout_en    = 1'b0;
        alert_pending = 1'b0;
        alert_mask    = 1'b0;
        for (int i = 0; i < 256; i++)
        begin
            rf[i]      = 8'(i) ^ 8'ha5;
            exp_mem[i] = i ^ 'ha5;
        end
        void'($urandom(32'h8b77));
        // Strap codes 0 to 5 and one of 6 or 7: silent during blackout, then Send Byte loads pointer
        for (int s = 0; s < 7; s++)
        begin
            strap_code = 3'(s < 6 ? s : 6 + $urandom % 2);
            reset_n = 1'b0;
            host.tick(3);
            reset_n = 1'b1;
            own = strap_addr(s);
            exp_ptr = 0;
            chk(16'(reg_ptr), 16'h0000);
            host.tick(20);
            wr_txn(own, 2, 24'h1234_00, 0, 1'b1, acks);
            chk(16'(acks), 16'h0000);
            chk_wr(1'b0, 16'h0000);
            for (int i = 0; i < BLACKOUT + 100 && ready !== 1'b1; i++)
                host.tick(1);
            host.tick(4);
            idx = 8'($urandom);
            wr_txn(own, 1, {idx, 16'h0000}, 0, 1'b1, acks);
            exp_ptr = idx;
            chk(16'(acks), 16'h0003);
            chk(16'(reg_ptr), 16'(exp_ptr));
            chk_wr(1'b0, 16'h0000);
        end
        $display("test strap_and_blackout done");
        // Back-to-back Write Byte, first one at the top index
        for (int k = 0; k < 4; k++)
        begin
            idx = (k == 0) ? 8'hff : 8'($urandom);
            dat = 8'($urandom);
            {timeout_en, alert_pending} = 2'($urandom);
            wr_txn(own, 2, {idx, dat, 8'h00}, 0, 1'b1, acks);
            exp_mem[idx] = dat;
            exp_ptr = idx;
            chk(16'(acks), 16'h0007);
            chk_wr(1'b1, {idx, dat});
        end
        $display("test write_byte done");
        // Read Byte with repeated start, then Receive Byte twice
        wr_txn(own, 1, 24'hff_0000, 0, 1'b0, acks);
        rd_txn(own, ack, got);
        exp_ptr = 8'hff;
        chk(16'(ack), 16'h0001);
        chk(16'(got), 16'(exp_mem[exp_ptr]));
        for (int k = 0; k < 2; k++)
        begin
            rd_txn(own, ack, got);
            chk(16'(got), 16'(exp_mem[exp_ptr]));
        end
        $display("test read_byte done");
        // Foreign address and a write with one byte too many
        wr_txn(own ^ 7'h01, 2, 24'h1077_00, 0, 1'b1, acks);
        chk(16'(acks), 16'h0000);
        rd_txn(own ^ 7'h01, ack, got);
        chk(16'(ack), 16'h0000);
        chk(16'(reg_ptr), 16'(exp_ptr));
        wr_txn(own, 3, 24'h10_7733, 0, 1'b1, acks);
        exp_ptr = 8'h10;
        chk(16'(acks), 16'h0007);
        chk_wr(1'b0, 16'h0000);
        rd_txn(own, ack, got);
        chk(16'(got), 16'(exp_mem[8'h10]));
        $display("test refusals done");
        // Long clock-low stretch: tolerated when off, resets protocol when on
        dat = 8'($urandom);
        timeout_en = 1'b0;
        wr_txn(own, 2, {8'h20, dat, 8'h00}, 250, 1'b1, acks);
        exp_mem[8'h20] = dat;
        exp_ptr = 8'h20;
        chk(16'(acks), 16'h0007);
        chk_wr(1'b1, {8'h20, dat});
        timeout_en = 1'b1;
        wr_txn(own, 2, 24'h2155_00, 250, 1'b1, acks);
        chk(16'(acks), 16'h0001);
        chk_wr(1'b0, 16'h0000);
        timeout_en = 1'b0;
        rd_txn(own, ack, got);
        chk(16'(got), 16'(exp_mem[exp_ptr]));
        $display("test timeout done");
        // Alert query: answered with own address, mask set, re-raised on clear
        alert_pending = 1'b1;
        host.tick(3);
        chk(16'(alert_oe), 16'h0001);
        rd_txn(`ALERT_QUERY_ADDR, ack, got);
        chk(16'(ack), 16'h0001);
        chk(16'(got), 16'({own, 1'b0}));
        chk(16'(alert_mask), 16'h0001);
        host.tick(3);
        chk(16'(alert_oe), 16'h0000);
        alert_mask = 1'b0;
        host.tick(3);
        chk(16'(alert_oe), 16'h0001);
        alert_pending = 1'b0;
        host.tick(3);
        rd_txn(`ALERT_QUERY_ADDR, ack, got);
        chk(16'(ack), 16'h0000);
        $display("test alert_query done");
        report_and_stop();
    end

endmodule // tb_top
